// >>> rtl/io_power_ctrl.sv
// usb io and power control register with its pin steering
`timescale 1ns/1ps
module io_power_ctrl (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  // immediate register access
  input  wire logic       reg_wr_en_i,
  input  wire logic       reg_rd_en_i,
  input  wire logic [5:0] reg_addr_i,
  input  wire logic [7:0] reg_wr_data_i,
  output logic      [7:0] reg_rd_data_o,
  output logic            reg_rd_valid_o,
  // operating mode from the mode controller
  input  wire logic       serial_mode_i,
  input  wire logic       audio_mode_i,
  input  wire logic       serial_transmit_enable_i,
  // line and supply control
  output logic            data_line_swap_o,
  output logic            serial_pin_swap_o,
  output logic            speaker_swap_o,
  output logic      [1:0] regulated_supply_output_o,
  output logic            charger_pullup_pos_line_o,
  output logic            charger_pullup_neg_line_o
);

  // ----------------------------------------------------------------
  // register decode and storage
  // ----------------------------------------------------------------
  io_power_pkg::access_kind_t kind;
  logic                       read_hit;
  logic [7:0]                 io_power_control_ff;
  logic [7:0]                 nxt_io_power_control;
  logic                       serial_active_ff;
  logic                       serial_seen_ff;

  io_power_addr_decode u_decode (
    .wr_en_i    (reg_wr_en_i),
    .addr_i     (reg_addr_i),
    .kind_o     (kind),
    .read_hit_o (read_hit)
  );

  always_comb begin
    nxt_io_power_control = io_power_control_ff;
    case (kind)
      io_power_pkg::ACC_WRITE: nxt_io_power_control = reg_wr_data_i;
      io_power_pkg::ACC_SET:   nxt_io_power_control = io_power_control_ff | reg_wr_data_i;
      io_power_pkg::ACC_CLEAR: nxt_io_power_control = io_power_control_ff & ~reg_wr_data_i;
      default:                 nxt_io_power_control = io_power_control_ff;
    endcase
    nxt_io_power_control = nxt_io_power_control & io_power_pkg::WRITABLE_MASK;
  end

  // reset values of both level fields
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      io_power_control_ff <= io_power_pkg::IO_POWER_RESET;
    end else begin
      io_power_control_ff <= nxt_io_power_control;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped addresses read zero, answer one cycle after the request
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rd_data_o  <= 8'h00;
      reg_rd_valid_o <= 1'b0;
    end else begin
      reg_rd_valid_o <= reg_rd_en_i;
      // same content at all three addresses
      if (reg_rd_en_i) begin
        reg_rd_data_o <= read_hit ? io_power_control_ff : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial mode entry tracking
  // ----------------------------------------------------------------
  // regulator keeps the usb level until transmit enable shows
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_active_ff <= 1'b0;
      serial_seen_ff   <= 1'b0;
    end else begin
      serial_seen_ff <= serial_mode_i;
      // level change gated by transmit enable
      if (!serial_mode_i) begin
        serial_active_ff <= 1'b0;
      end else if (serial_transmit_enable_i) begin
        serial_active_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin steering and supply level
  // ----------------------------------------------------------------
  logic       swap_bit;
  logic [1:0] serial_level;
  logic [1:0] usb_level;
  logic [1:0] nxt_supply;

  assign swap_bit     = io_power_control_ff[io_power_pkg::SWAP_BIT];
  assign serial_level = io_power_control_ff[io_power_pkg::SERIAL_LVL_LSB +: 2];
  assign usb_level    = io_power_control_ff[io_power_pkg::USB_LVL_LSB +: 2];

  always_comb begin
    // usb field in sync and low-power modes, and in serial-link mode until transmit enable
    nxt_supply = usb_level;
    if (audio_mode_i) begin
      nxt_supply = io_power_pkg::LEVEL_3V30;
    // serial field applies once serial mode is live
    end else if (serial_active_ff) begin
      nxt_supply = serial_level;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regulated_supply_output_o <= io_power_pkg::LEVEL_3V30;
    end else begin
      // level code passed unchanged to the regulator
      regulated_supply_output_o <= nxt_supply;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_line_swap_o  <= 1'b0;
      serial_pin_swap_o <= 1'b0;
      speaker_swap_o    <= 1'b0;
    end else begin
      data_line_swap_o  <= swap_bit && !audio_mode_i;
      serial_pin_swap_o <= swap_bit && serial_mode_i;
      speaker_swap_o    <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      charger_pullup_pos_line_o <= 1'b0;
      charger_pullup_neg_line_o <= 1'b0;
    end else begin
      // pull-up enables, forced in serial mode
      charger_pullup_pos_line_o <= io_power_control_ff[io_power_pkg::PULLUP_POS_BIT] || serial_mode_i;
      charger_pullup_neg_line_o <= io_power_control_ff[io_power_pkg::PULLUP_NEG_BIT] || serial_mode_i;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    io_power_control_ff[io_power_pkg::RESERVED_BIT] == 1'b0)
    else $error("reserved bit set");

  a_set_ors_in: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (kind == io_power_pkg::ACC_SET) |=> ((io_power_control_ff & ($past(reg_wr_data_i) & 8'hFE)) ==
      ($past(reg_wr_data_i) & 8'hFE)) && ((io_power_control_ff | $past(io_power_control_ff)) == io_power_control_ff))
    else $error("set access lost a bit");

  a_clear_removes: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (kind == io_power_pkg::ACC_CLEAR) |=>
      (io_power_control_ff == ($past(io_power_control_ff) & ~$past(reg_wr_data_i))))
    else $error("clear access wrong");

  a_write_decode: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_wr_en_i && reg_addr_i == io_power_pkg::IO_POWER_WR_ADDR) |=>
      (io_power_control_ff == ($past(reg_wr_data_i) & 8'hFE)))
    else $error("plain write not stored");

  a_read_alias: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_rd_en_i && reg_addr_i == io_power_pkg::IO_POWER_CLR_ADDR) |=>
      (reg_rd_valid_o && reg_rd_data_o == $past(io_power_control_ff)))
    else $error("read at clear address wrong");

  a_audio_level: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    audio_mode_i |=> (regulated_supply_output_o == 2'h0))
    else $error("audio mode level not 3.3V");

  a_usb_level: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!audio_mode_i && !serial_mode_i) ##1 !audio_mode_i |=> (regulated_supply_output_o == $past(usb_level)))
    else $error("usb level not applied");

  a_serial_wait: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!serial_seen_ff && serial_mode_i && !serial_transmit_enable_i && !audio_mode_i) |=>
      (regulated_supply_output_o == $past(usb_level)))
    else $error("serial level applied too early");

  a_serial_level: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (serial_mode_i && serial_transmit_enable_i && !audio_mode_i) ##1 (serial_mode_i && !audio_mode_i) |=>
      (regulated_supply_output_o == $past(serial_level)))
    else $error("serial level not applied");

  a_pullup_forced: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    serial_mode_i |=> (charger_pullup_pos_line_o && charger_pullup_neg_line_o))
    else $error("pull-ups not forced in serial mode");

  a_swap_follow: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (swap_bit && !audio_mode_i) |=> data_line_swap_o)
    else $error("data lines not swapped");

  a_speaker_fixed: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    audio_mode_i |=> !speaker_swap_o && !data_line_swap_o)
    else $error("speaker outputs swapped");

endmodule

// >>> rtl/io_power_pkg.sv
// constants for the usb io and power control register block
package io_power_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] VENDOR_FIRST_ADDR = 6'h30;
  localparam logic [5:0] VENDOR_LAST_ADDR  = 6'h3F;
  localparam logic [5:0] IO_POWER_WR_ADDR  = 6'h39;
  localparam logic [5:0] IO_POWER_SET_ADDR = 6'h3A;
  localparam logic [5:0] IO_POWER_CLR_ADDR = 6'h3B;

  // ----------------------------------------------------------------
  // field positions and reset value
  // ----------------------------------------------------------------
  localparam int         RESERVED_BIT      = 0;
  localparam int         SWAP_BIT          = 1;
  localparam int         SERIAL_LVL_LSB    = 2;
  localparam int         PULLUP_POS_BIT    = 4;
  localparam int         PULLUP_NEG_BIT    = 5;
  localparam int         USB_LVL_LSB       = 6;
  localparam logic [7:0] IO_POWER_RESET    = 8'h04;
  localparam logic [7:0] WRITABLE_MASK     = 8'hFE;

  // ----------------------------------------------------------------
  // regulator level codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LEVEL_3V30        = 2'h0;
  localparam logic [1:0] LEVEL_3V00        = 2'h1;
  localparam logic [1:0] LEVEL_2V75        = 2'h2;
  localparam logic [1:0] LEVEL_2V50        = 2'h3;

  // register access commands
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_WRITE,
    ACC_SET,
    ACC_CLEAR
  } access_kind_t;

endpackage

// >>> rtl/io_power_addr_decode.sv
// address decode of the io and power control register
`timescale 1ns/1ps
module io_power_addr_decode (
  // register request
  input  wire logic       wr_en_i,
  input  wire logic [5:0] addr_i,
  // decoded access
  output io_power_pkg::access_kind_t kind_o,
  output logic            read_hit_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    kind_o = io_power_pkg::ACC_NONE;
    if (wr_en_i) begin
      case (addr_i)
        io_power_pkg::IO_POWER_WR_ADDR:  kind_o = io_power_pkg::ACC_WRITE;
        io_power_pkg::IO_POWER_SET_ADDR: kind_o = io_power_pkg::ACC_SET;
        io_power_pkg::IO_POWER_CLR_ADDR: kind_o = io_power_pkg::ACC_CLEAR;
        default:                         kind_o = io_power_pkg::ACC_NONE;
      endcase
    end
  end

  assign read_hit_o = (addr_i >= io_power_pkg::IO_POWER_WR_ADDR) && (addr_i <= io_power_pkg::IO_POWER_CLR_ADDR);

endmodule

// >>> bench/link_model.sv
// link controller model issuing immediate register accesses
`timescale 1ns/1ps
module link_model (
  // clock
  input  wire logic       core_clk_i,
  // register request
  output logic            reg_wr_en_o,
  output logic            reg_rd_en_o,
  output logic      [5:0] reg_addr_o,
  output logic      [7:0] reg_wr_data_o,
  // read answer
  input  wire logic [7:0] reg_rd_data_i,
  input  wire logic       reg_rd_valid_i
);
  initial begin
    reg_wr_en_o = 1'b0;
    reg_rd_en_o = 1'b0;
    reg_addr_o = 6'h00;
    reg_wr_data_o = 8'h00;
  end

  // plain immediate write
  // released lines show the inverse so stale values never pass
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wr_data_o <= d;
    reg_wr_en_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_en_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wr_data_o <= ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_en_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_en_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rd_data_i;
    v = reg_rd_valid_i;
  endtask
endmodule

// >>> bench/usb_io_power_mgmt_register_tb.sv
// self-checking bench for the io and power control register
`timescale 1ns/1ps
module usb_io_power_mgmt_register_tb;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } row_t;
  logic       core_clk_i, reset_n_i, reg_wr_en_i, reg_rd_en_i, reg_rd_valid_o;
  logic [5:0] reg_addr_i;
  logic [7:0] reg_wr_data_i, reg_rd_data_o, rv;
  logic       serial_mode_i, audio_mode_i, serial_transmit_enable_i, ok;
  logic       data_line_swap_o, serial_pin_swap_o, speaker_swap_o;
  logic       charger_pullup_pos_line_o, charger_pullup_neg_line_o;
  logic [1:0] regulated_supply_output_o;
  wire  [7:0] outs = {1'b0, data_line_swap_o, serial_pin_swap_o, speaker_swap_o,
                      regulated_supply_output_o, charger_pullup_pos_line_o, charger_pullup_neg_line_o};
  int         err_count, check_count, cycles;
  row_t       rows [9] = '{'{6'h39, 8'hFF, 8'hFE}, '{6'h3B, 8'h0F, 8'hF0}, '{6'h3A, 8'h05, 8'hF4},
                           '{6'h39, 8'h12, 8'h12}, '{6'h30, 8'hFF, 8'h12}, '{6'h39, 8'h40, 8'h40},
                           '{6'h3A, 8'h80, 8'hC0}, '{6'h3B, 8'h40, 8'h80}, '{6'h3B, 8'hFF, 8'h00}};

  io_power_ctrl DUT (.core_clk_i, .reset_n_i, .reg_wr_en_i, .reg_rd_en_i, .reg_addr_i, .reg_wr_data_i,
    .reg_rd_data_o, .reg_rd_valid_o, .serial_mode_i, .audio_mode_i, .serial_transmit_enable_i,
    .data_line_swap_o, .serial_pin_swap_o, .speaker_swap_o, .regulated_supply_output_o,
    .charger_pullup_pos_line_o, .charger_pullup_neg_line_o);

  link_model lm (.core_clk_i, .reg_wr_en_o(reg_wr_en_i), .reg_rd_en_o(reg_rd_en_i), .reg_addr_o(reg_addr_i),
    .reg_wr_data_o(reg_wr_data_i), .reg_rd_data_i(reg_rd_data_o), .reg_rd_valid_i(reg_rd_valid_o));

  // expected outputs from register value, modes and transmit flag
  function automatic logic [7:0] exp_outs(input logic [7:0] r, input logic s, input logic a, input logic f);
    logic [1:0] lvl;
    // audio pins the supply at 3.3V, else pick the field
    lvl = a ? 2'h0 : (s && f) ? r[3:2] : r[7:6];
    return {1'b0, r[1] & ~a, r[1] & s, 1'b0, lvl, r[4] | s, r[5] | s};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // whole run is well under a thousand cycles
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    err_count = 0;
    check_count = 0;
    cycles = 0;
    reset_n_i = 1'b0;
    serial_mode_i = 1'b0;
    audio_mode_i = 1'b0;
    serial_transmit_enable_i = 1'b0;
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    lm.rd(6'h39, rv, ok);
    check(rv, 8'h04);
    check({7'h00, ok}, 8'h01);
    foreach (rows[i]) begin
      lm.wr(rows[i].addr, rows[i].data);
      lm.rd(6'h39 + 6'(i % 3), rv, ok);
      check(rv, rows[i].exp);
      check(outs, exp_outs(rows[i].exp, 1'b0, 1'b0, 1'b0));
    end
    lm.rd(6'h3C, rv, ok);
    check({rv[7:1], ok}, 8'h01);
    lm.wr(6'h39, 8'h8E);
    serial_mode_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 check(outs, exp_outs(8'h8E, 1'b1, 1'b0, 1'b0));
    @(posedge core_clk_i);
    serial_transmit_enable_i <= 1'b1;
    @(posedge core_clk_i);
    #1 check(outs, exp_outs(8'h8E, 1'b1, 1'b0, 1'b0));
    @(posedge core_clk_i);
    #1 check(outs, exp_outs(8'h8E, 1'b1, 1'b0, 1'b1));
    @(posedge core_clk_i);
    audio_mode_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 check(outs, exp_outs(8'h8E, 1'b1, 1'b1, 1'b1));
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    serial_mode_i <= 1'b0;
    audio_mode_i <= 1'b0;
    serial_transmit_enable_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    lm.rd(6'h3B, rv, ok);
    check(rv, 8'h04);
    check(outs, exp_outs(8'h04, 1'b0, 1'b0, 1'b0));
    finish_test();
  end
endmodule
